// [core/drc_defs.svh]
// Constants for the dynamic RAM array controller: field positions, reset values and timing counts.
`ifndef DRC_DEFS_SVH
`define DRC_DEFS_SVH

`define DRC_HALF_W          6
`define DRC_CELL_ADDR_W     12
`define DRC_ROW_LSB         6
`define DRC_COL_LSB         0
`define DRC_BANK_W          2
`define DRC_MAX_BANKS       4
`define DRC_DATA_W          16
`define DRC_WORD_W          18
`define DRC_PARITY_LSB      16
`define DRC_REFRESH_COL     6'h00
`define DRC_REFRESH_ROW_RST 6'h00
`define DRC_CLK_PERIOD_NS   10
`define DRC_REFRESH_NS      25000
`define DRC_REFRESH_CYC     (`DRC_REFRESH_NS / `DRC_CLK_PERIOD_NS)
`define DRC_ACCESS_NS       350
`define DRC_ACCESS_CYC      ((`DRC_ACCESS_NS + `DRC_CLK_PERIOD_NS - 1) / `DRC_CLK_PERIOD_NS)
`define DRC_SYNC_STAGES     2
`define DRC_TIMER_W         12
`define DRC_PHASE_W         6

`endif

// [core/drc_pkg.sv]
// Types shared by the dynamic RAM array controller.
`include "drc_defs.svh"

package drc_pkg;

    typedef enum logic [6:0] {
        ST_IDLE   = 7'h01,
        ST_ROWADR = 7'h02,
        ST_RAS    = 7'h04,
        ST_COLADR = 7'h08,
        ST_ACCESS = 7'h10,
        ST_DONE   = 7'h20,
        ST_PRE    = 7'h40
    } ctlState_t;

    typedef struct packed {
        logic                          msync;
        logic                          write;
        logic                          present;
        logic [`DRC_BANK_W-1:0]        bank;
        logic [`DRC_CELL_ADDR_W-1:0]   cellAddr;
        logic [`DRC_WORD_W-1:0]        data;
    } hostPins_t;

    typedef struct packed {
        logic [`DRC_MAX_BANKS-1:0]     rasN;
        logic                          casN;
        logic                          csN;
        logic                          writeN;
        logic [`DRC_HALF_W-1:0]        addr;
    } arrayCtl_t;

    typedef struct packed {
        ctlState_t                     state;
        logic [`DRC_TIMER_W-1:0]       refTimer;
        logic                          refPending;
        logic [`DRC_HALF_W-1:0]        refRow;
        logic [`DRC_PHASE_W-1:0]       phase;
        logic                          isRefresh;
        logic                          isWrite;
        logic [`DRC_BANK_W-1:0]        bank;
        logic [`DRC_CELL_ADDR_W-1:0]   cellAddr;
        logic [`DRC_WORD_W-1:0]        wrData;
        logic [`DRC_WORD_W-1:0]        rdData;
        logic                          ssync;
        logic                          dataOe;
        arrayCtl_t                     arr;
        hostPins_t                     pinSync1;
        hostPins_t                     pinSync2;
        logic [`DRC_WORD_W-1:0]        readSync1;
        logic [`DRC_WORD_W-1:0]        readSync2;
    } ctl_t;

endpackage

// [core/dynamic_ram_array_control.sv]
// Strobe sequencer, address multiplexer, data latches and refresh engine for a dynamic RAM array.
`timescale 1ns/1ps
`include "drc_defs.svh"

module dynamic_ram_array_control #(
    parameter int unsigned BANKS       = `DRC_MAX_BANKS,
    parameter bit          PARITY      = 1'b1,
    parameter int unsigned REFRESH_CYC = `DRC_REFRESH_CYC,
    parameter int unsigned ACCESS_CYC  = `DRC_ACCESS_CYC
) (
    input  wire logic                          core_clk,
    input  wire logic                          resetn,
    input  wire logic                          busMsync,
    input  wire logic                          busWrite,
    input  wire logic                          addrPresent,
    input  wire logic [`DRC_BANK_W-1:0]        busBank,
    input  wire logic [`DRC_CELL_ADDR_W-1:0]   busCellAddr,
    input  wire logic [`DRC_WORD_W-1:0]        busDataIn,
    output logic      [`DRC_WORD_W-1:0]        busDataOut,
    output logic                               busDataOe,
    output logic                               busSsync,
    output logic      [`DRC_HALF_W-1:0]        muxedCellAddr,
    output logic      [`DRC_MAX_BANKS-1:0]     rowStrobeN,
    output logic                               colStrobeN,
    output logic                               chipSelN,
    output logic                               writeN,
    output logic      [`DRC_WORD_W-1:0]        arrayWriteLines,
    input  wire logic [`DRC_WORD_W-1:0]        arrayReadLines
);

    // Read data passes a two-stage synchroniser, so the wait after the row strobe covers it too.
    localparam logic [`DRC_PHASE_W-1:0] ACCESS_WAIT = `DRC_PHASE_W'(ACCESS_CYC + `DRC_SYNC_STAGES);
    localparam logic [`DRC_TIMER_W-1:0] TIMER_LOAD  = `DRC_TIMER_W'(REFRESH_CYC - 1);

    drc_pkg::ctl_t q;
    drc_pkg::ctl_t d;

    // Row select for one bank number, or for every bank when all is set, limited to installed banks.
    function automatic logic [`DRC_MAX_BANKS-1:0] bankMask(input logic [`DRC_BANK_W-1:0] bank,
                                                           input logic                   all);
        logic [`DRC_MAX_BANKS-1:0] mask;
        mask = '0;
        for (int i = 0; i < `DRC_MAX_BANKS; i++) begin
            if (i < BANKS && (all || bank == `DRC_BANK_W'(i))) begin
                mask[i] = 1'b1;
            end
        end
        return mask;
    endfunction

    // Without parity the two extra bits are never stored and read back as zero.
    function automatic logic [`DRC_WORD_W-1:0] keepParity(input logic [`DRC_WORD_W-1:0] word);
        logic [`DRC_WORD_W-1:0] result;
        result = word;
        if (!PARITY) begin
            result[`DRC_WORD_W-1:`DRC_PARITY_LSB] = '0;
        end
        return result;
    endfunction

    logic                          reqValid;
    drc_pkg::hostPins_t            pins;

    assign pins     = q.pinSync2;
    assign reqValid = pins.msync && pins.present && (bankMask(pins.bank, 1'b0) != '0);

    always_comb begin
        d = q;

        d.pinSync1.msync    = busMsync;
        d.pinSync1.write    = busWrite;
        d.pinSync1.present  = addrPresent;
        d.pinSync1.bank     = busBank;
        d.pinSync1.cellAddr = busCellAddr;
        d.pinSync1.data     = busDataIn;
        d.pinSync2          = q.pinSync1;
        d.readSync1         = arrayReadLines;
        d.readSync2         = q.readSync1;

        // The timer keeps running during bus cycles; a tick in the cycle a refresh starts still counts.
        if (q.refTimer == '0) begin
            d.refTimer = TIMER_LOAD;
        end else begin
            d.refTimer = q.refTimer - `DRC_TIMER_W'(1);
        end

        case (q.state)
            drc_pkg::ST_IDLE: begin
                d.phase = '0;
                if (q.refPending) begin
                    d.refPending = 1'b0;
                    d.isRefresh  = 1'b1;
                    d.isWrite    = 1'b0;
                    d.arr.csN    = 1'b1;
                    d.arr.writeN = 1'b1;
                    d.arr.addr   = q.refRow;
                    d.state      = drc_pkg::ST_ROWADR;
                end else if (reqValid) begin
                    d.isRefresh  = 1'b0;
                    d.isWrite    = pins.write;
                    d.bank       = pins.bank;
                    d.cellAddr   = pins.cellAddr;
                    d.wrData     = keepParity(pins.data);
                    d.arr.csN    = 1'b0;
                    d.arr.writeN = ~pins.write;
                    d.arr.addr   = pins.cellAddr[`DRC_ROW_LSB +: `DRC_HALF_W];
                    d.state      = drc_pkg::ST_ROWADR;
                end
            end

            drc_pkg::ST_ROWADR: begin
                // Row half has had a full cycle of setup before the strobe falls.
                if (q.isRefresh) begin
                    d.arr.rasN = ~bankMask(q.bank, 1'b1);
                end else begin
                    d.arr.rasN = ~bankMask(q.bank, 1'b0);
                end
                d.state = drc_pkg::ST_RAS;
            end

            drc_pkg::ST_RAS: begin
                d.phase = q.phase + `DRC_PHASE_W'(1);
                if (q.isRefresh) begin
                    d.arr.addr = `DRC_REFRESH_COL;
                end else begin
                    d.arr.addr = q.cellAddr[`DRC_COL_LSB +: `DRC_HALF_W];
                end
                d.state = drc_pkg::ST_COLADR;
            end

            drc_pkg::ST_COLADR: begin
                d.phase    = q.phase + `DRC_PHASE_W'(1);
                d.arr.casN = 1'b0;
                d.state    = drc_pkg::ST_ACCESS;
            end

            drc_pkg::ST_ACCESS: begin
                d.phase = q.phase + `DRC_PHASE_W'(1);
                if (q.phase >= ACCESS_WAIT) begin
                    d.arr.rasN   = '1;
                    d.arr.casN   = 1'b1;
                    d.arr.csN    = 1'b1;
                    d.arr.writeN = 1'b1;
                    if (q.isRefresh) begin
                        d.refRow    = q.refRow + `DRC_HALF_W'(1);
                        d.isRefresh = 1'b0;
                        d.state     = drc_pkg::ST_PRE;
                    end else begin
                        if (!q.isWrite) begin
                            d.rdData = keepParity(q.readSync2);
                        end
                        d.ssync  = 1'b1;
                        d.dataOe = ~q.isWrite;
                        d.state  = drc_pkg::ST_DONE;
                    end
                end
            end

            drc_pkg::ST_DONE: begin
                // Strobes are already high here, so this wait doubles as precharge.
                if (!pins.msync) begin
                    d.ssync  = 1'b0;
                    d.dataOe = 1'b0;
                    d.state  = drc_pkg::ST_PRE;
                end
            end

            drc_pkg::ST_PRE: begin
                d.phase = '0;
                d.state = drc_pkg::ST_IDLE;
            end

            default: begin
                d.arr.rasN   = '1;
                d.arr.casN   = 1'b1;
                d.arr.csN    = 1'b1;
                d.arr.writeN = 1'b1;
                d.ssync      = 1'b0;
                d.dataOe     = 1'b0;
                d.state      = drc_pkg::ST_IDLE;
            end
        endcase

        // A timer tick in the same cycle that a refresh starts is kept, not lost.
        if (q.refTimer == '0) begin
            d.refPending = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            q            <= '0;
            q.state      <= drc_pkg::ST_IDLE;
            q.refTimer   <= TIMER_LOAD;
            q.refRow     <= `DRC_REFRESH_ROW_RST;
            q.arr.rasN   <= '1;
            q.arr.casN   <= 1'b1;
            q.arr.csN    <= 1'b1;
            q.arr.writeN <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // The chips float unselected rows; the controller latches read data in rdData and write data in wrData, and drives every pin from registers.
    assign muxedCellAddr   = q.arr.addr;
    assign rowStrobeN      = q.arr.rasN;
    assign colStrobeN      = q.arr.casN;
    assign chipSelN        = q.arr.csN;
    assign writeN          = q.arr.writeN;
    assign arrayWriteLines = q.wrData;
    assign busDataOut      = q.rdData;
    assign busDataOe       = q.dataOe;
    assign busSsync        = q.ssync;

endmodule

// [verification/dynamic_ram_array_control_asserts.sv]
// Port checks for the dynamic RAM array controller.
`timescale 1ns/1ps
module dynamic_ram_array_control_asserts #(
    parameter int unsigned BANKS       = 4,
    parameter int unsigned REFRESH_CYC = 2500,
    parameter int unsigned ACCESS_CYC  = 35
) (
    input wire logic        core_clk,
    input wire logic        resetn,
    input wire logic        busMsync,
    input wire logic        busSsync,
    input wire logic [5:0]  muxedCellAddr,
    input wire logic [3:0]  rowStrobeN,
    input wire logic        colStrobeN,
    input wire logic        chipSelN,
    input wire logic        writeN,
    input wire logic [17:0] arrayWriteLines
);
    localparam int ACC = ACCESS_CYC;
    logic        ras;
    logic        refStart;
    logic        rasPrev_q;
    logic [5:0]  lastRow_q;
    logic [12:0] gap_q;
    assign ras = rowStrobeN != 4'hf;
    // Only a refresh strobes rows with chip select high.
    assign refStart = ras && chipSelN && !rasPrev_q;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rasPrev_q <= 1'b0;
            lastRow_q <= 6'h3f;
            gap_q     <= 13'h0000;
        end else begin
            rasPrev_q <= ras;
            lastRow_q <= refStart ? muxedCellAddr : lastRow_q;
            gap_q     <= refStart ? 13'h0000 : gap_q + 13'h0001;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    sequence s_colAfterRow; ##2 $fell(colStrobeN); endsequence
    sequence s_rowHeld; ras throughout (##ACC 1'b1); endsequence
    property p_rowFirst; $rose(ras) |-> s_colAfterRow; endproperty
    a_rowFirst: assert property (p_rowFirst) else $error("column strobe late");
    property p_access; $rose(ras) |-> s_rowHeld; endproperty
    a_access: assert property (p_access) else $error("row strobe too short");
    property p_refreshCs; ras && chipSelN |-> writeN && !busSsync; endproperty
    a_refreshCs: assert property (p_refreshCs) else $error("refresh drives host");
    property p_refreshCol; $fell(colStrobeN) && chipSelN |-> muxedCellAddr == 6'h00; endproperty
    a_refreshCol: assert property (p_refreshCol) else $error("refresh column");
    // The cast keeps the inversion four bits wide; widened first, its top bit would read as one.
    property p_decode; ras && !chipSelN |-> $onehot(~rowStrobeN) && 4'(~rowStrobeN) < (5'h01 << BANKS); endproperty
    a_decode: assert property (p_decode) else $error("row strobe decode");
    property p_refreshRow; refStart |-> muxedCellAddr == lastRow_q + 6'h01; endproperty
    a_refreshRow: assert property (p_refreshRow) else $error("refresh row order");
    property p_period; gap_q < REFRESH_CYC + 100; endproperty
    a_period: assert property (p_period) else $error("refresh overdue");
    property p_writeHold; !writeN && ras && rasPrev_q |-> $stable(arrayWriteLines); endproperty
    a_writeHold: assert property (p_writeHold) else $error("write word moved");
    property p_ssyncHold; busSsync && busMsync |=> busSsync; endproperty
    a_ssyncHold: assert property (p_ssyncHold) else $error("slave sync dropped");
    property p_noOverlap; $rose(busSsync) |-> !ras; endproperty
    a_noOverlap: assert property (p_noOverlap) else $error("strobes still low");
endmodule
bind dynamic_ram_array_control dynamic_ram_array_control_asserts #(
    .BANKS(BANKS), .REFRESH_CYC(REFRESH_CYC), .ACCESS_CYC(ACCESS_CYC)) chk (
    .core_clk(core_clk), .resetn(resetn), .busMsync(busMsync), .busSsync(busSsync),
    .muxedCellAddr(muxedCellAddr), .rowStrobeN(rowStrobeN), .colStrobeN(colStrobeN),
    .chipSelN(chipSelN), .writeN(writeN), .arrayWriteLines(arrayWriteLines));

// [verification/dram_rows_model.sv]
// Behavioural chip rows answering the controller's array pins.
`timescale 1ns/1ps
module dram_rows_model (
    input  wire logic        core_clk,
    input  wire logic [5:0]  muxedCellAddr,
    input  wire logic [3:0]  rowStrobeN,
    input  wire logic        colStrobeN,
    input  wire logic        chipSelN,
    input  wire logic        writeN,
    input  wire logic [17:0] arrayWriteLines,
    output logic      [17:0] arrayReadLines
);
    logic [17:0] mem [int];
    logic [17:0] outLatch = 18'h0_0000;
    logic        outOn    = 1'b0;
    logic [3:0]  rasPrev  = 4'hf;
    logic        casPrev  = 1'b1;
    logic [9:0]  rowKey   = 10'h000;
    logic [15:0] key;
    assign key = {rowKey, muxedCellAddr};
    // A floating output shows the inverse of its last value, so stale data never reads back.
    assign arrayReadLines = outOn ? outLatch : ~outLatch;
    always @(posedge core_clk) begin
        if (rowStrobeN != 4'hf && rasPrev == 4'hf)
            rowKey <= {~rowStrobeN, muxedCellAddr};
        if (!colStrobeN && casPrev) begin
            if (chipSelN || rowStrobeN == 4'hf)
                outOn <= 1'b0;
            else if (!writeN) begin
                mem[key] = arrayWriteLines;
                outLatch <= 18'h3_ffff;
                outOn    <= 1'b1;
            end else begin
                outLatch <= mem.exists(key) ? mem[key] : 18'h0_0000;
                outOn    <= 1'b1;
            end
        end
        rasPrev <= rowStrobeN;
        casPrev <= colStrobeN;
    end
endmodule

// [verification/dynamic_ram_array_control_tb_top.sv]
// Self-checking bench for the dynamic RAM array controller.
`timescale 1ns/1ps
module dynamic_ram_array_control_tb_top;
    logic        core_clk, resetn, busMsync, busWrite, addrPresent, busDataOe, busSsync;
    logic        colStrobeN, chipSelN, writeN;
    logic [1:0]  busBank;
    logic [11:0] busCellAddr;
    logic [17:0] busDataIn, busDataOut, arrayWriteLines, arrayReadLines;
    logic [5:0]  muxedCellAddr;
    logic [3:0]  rowStrobeN;
    logic [3:0]  rasSeen = 4'hf;
    logic        ssPrev  = 1'b0;
    logic [17:0] expQ [$];
    logic [17:0] shadow [int];
    logic [13:0] keys [12];
    int          n_mismatch = 0;
    int          n_compared = 0;
    int          nRef       = 0;
    // Bank 3 is not installed, so a present address there must be refused.
    dynamic_ram_array_control #(.BANKS(3), .PARITY(1'b1), .REFRESH_CYC(60)) dut (
        .core_clk       (core_clk),
        .resetn         (resetn),
        .busMsync       (busMsync),
        .busWrite       (busWrite),
        .addrPresent    (addrPresent),
        .busBank        (busBank),
        .busCellAddr    (busCellAddr),
        .busDataIn      (busDataIn),
        .busDataOut     (busDataOut),
        .busDataOe      (busDataOe),
        .busSsync       (busSsync),
        .muxedCellAddr  (muxedCellAddr),
        .rowStrobeN     (rowStrobeN),
        .colStrobeN     (colStrobeN),
        .chipSelN       (chipSelN),
        .writeN         (writeN),
        .arrayWriteLines(arrayWriteLines),
        .arrayReadLines (arrayReadLines)
    );
    dram_rows_model rows (
        .core_clk       (core_clk),
        .muxedCellAddr  (muxedCellAddr),
        .rowStrobeN     (rowStrobeN),
        .colStrobeN     (colStrobeN),
        .chipSelN       (chipSelN),
        .writeN         (writeN),
        .arrayWriteLines(arrayWriteLines),
        .arrayReadLines (arrayReadLines)
    );
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic summarize();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(string what, logic [17:0] seen, logic [17:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic waitSs(logic lvl);
        int i;
        i = 0;
        do begin
            @(negedge core_clk);
            i++;
        end while (busSsync !== lvl && i < 400);
        if (busSsync !== lvl) begin
            check("slave sync", 18'(busSsync), 18'(lvl));
            summarize();
        end
    endtask
    task automatic busCycle(logic wr, logic [13:0] key, logic [17:0] d);
        if (wr)
            shadow[key] = d;
        else
            expQ.push_back(shadow[key]);
        @(posedge core_clk);
        busMsync    <= 1'b1;
        busWrite    <= wr;
        addrPresent <= 1'b1;
        busBank     <= key[13:12];
        busCellAddr <= key[11:0];
        busDataIn   <= d;
        waitSs(1'b1);
        check("data enable", 18'(busDataOe), 18'(!wr));
        @(posedge core_clk);
        busMsync <= 1'b0;
        waitSs(1'b0);
    endtask
    task automatic refused(logic pres, logic [1:0] bank);
        logic hit;
        hit = 1'b0;
        @(posedge core_clk);
        busMsync    <= 1'b1;
        addrPresent <= pres;
        busBank     <= bank;
        repeat (120) begin
            @(negedge core_clk);
            hit = hit | busSsync | (!chipSelN && rowStrobeN != 4'hf);
        end
        check("refused cycle", 18'(hit), 18'h0_0000);
        @(posedge core_clk);
        busMsync <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask
    always @(negedge core_clk) begin
        if (chipSelN === 1'b1 && rowStrobeN !== 4'hf && rasSeen === 4'hf)
            nRef++;
        if (busSsync === 1'b1 && ssPrev !== 1'b1 && busDataOe === 1'b1)
            check("read word", busDataOut, expQ.size() > 0 ? expQ.pop_front() : 18'hx);
        rasSeen = rowStrobeN;
        ssPrev  = busSsync;
    end
    initial begin
        resetn = 1'b0;
        {busMsync, busWrite, addrPresent, busBank, busCellAddr, busDataIn} = '0;
        void'($urandom(32'h4dea_7e31));
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            keys[i] = i == 0 ? 14'h0000 : i == 1 ? 14'h2fff : {2'($urandom % 3), 12'($urandom)};
            busCycle(1'b1, keys[i], 18'($urandom));
        end
        for (int i = 11; i >= 0; i--)
            busCycle(1'b0, keys[i], 18'h0_0000);
        $display("test transfers done");
        refused(1'b0, 2'h0);
        refused(1'b1, 2'h3);
        $display("test refusals done");
        nRef = 0;
        repeat (4200) @(posedge core_clk);
        check("refresh count", 18'(nRef >= 69 && nRef <= 71), 18'h0_0001);
        busCycle(1'b0, keys[2], 18'h0_0000);
        check("queue left", 18'(expQ.size()), 18'h0_0000);
        $display("test refresh done");
        summarize();
    end
endmodule
